/* verilog/servo_io_pkg.sv */
// Constants, register map and encodings for the servo position I/O sequencer.
// Assumes a 250 MHz hclk and an AHB-Lite master with word-sized single transfers.
package servo_io_pkg;

  // Timing base
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned NS_PER_US      = 1000;
  localparam int unsigned NS_PER_MS      = 1000000;
  localparam int unsigned CYC_PER_MS     = NS_PER_MS / CLK_PERIOD_NS;
  // Settle time between excitation and brake release (least time, rounded up)
  localparam int unsigned EXCITE_TIME_US = 1000;
  localparam int unsigned EXCITE_CYC     = (EXCITE_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Settle time between brake release and ready
  localparam int unsigned BRAKE_TIME_US  = 1000;
  localparam int unsigned BRAKE_CYC      = (BRAKE_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Quiet time without pulses after which the motor counts as stopped
  localparam int unsigned IDLE_TIME_US   = 500;
  localparam int unsigned IDLE_CYC       = (IDLE_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 24;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_COMPLETE = 8'h04;
  localparam logic [7:0] OFS_NEAR     = 8'h08;
  localparam logic [7:0] OFS_MOVE_MIN = 8'h0c;
  localparam logic [7:0] OFS_PRESET   = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_DEVIATE  = 8'h18;
  localparam logic [7:0] OFS_POSITION = 8'h1c;
  localparam logic [7:0] OFS_DSET0    = 8'h20;

  // Control register fields
  localparam int unsigned CTRL_SON_NC   = 0;
  localparam int unsigned CTRL_ANALOG   = 1;
  localparam int unsigned CTRL_ABS      = 2;
  localparam int unsigned CTRL_TEST     = 3;
  localparam int unsigned CTRL_SEL1_LO  = 4;
  localparam int unsigned CTRL_SEL2     = 6;
  localparam logic [6:0]  CTRL_RST      = 7'h52;

  // Output selection 1 codes
  localparam logic [1:0] SEL1_NONE   = 2'h0;
  localparam logic [1:0] SEL1_MOTION = 2'h1;
  localparam logic [1:0] SEL1_BRAKE  = 2'h2;

  // Reset values
  localparam logic [15:0] MOVE_MIN_RST  = 16'h000a;
  localparam logic [31:0] BAND_RST      = 32'h0000_0001;
  localparam logic [8:0]  LIMIT_RST     = 9'h000;
  localparam logic [7:0]  DAMP_RST      = 8'h1e;
  localparam logic [8:0]  TORQUE_CEIL   = 9'h12c;
  localparam int unsigned DSET_DAMP_LO  = 16;
  localparam int unsigned NUM_DSETS     = 4;

  // Positions of the pin inputs in the synchroniser vector
  localparam int unsigned PIN_SON    = 0;
  localparam int unsigned PIN_CLR    = 1;
  localparam int unsigned PIN_PREQ   = 2;
  localparam int unsigned PIN_PRESET = 3;
  localparam int unsigned PIN_FREE   = 4;
  localparam int unsigned PIN_CAP    = 5;
  localparam int unsigned PIN_SEL_LO = 6;
  localparam int unsigned PIN_SEL_HI = 7;
  localparam int unsigned PIN_CMD    = 8;
  localparam int unsigned PIN_CDIR   = 9;
  localparam int unsigned PIN_FB     = 10;
  localparam int unsigned PIN_FDIR   = 11;
  localparam int unsigned PIN_MAINPW = 12;
  localparam int unsigned PIN_FAULT  = 13;
  localparam int unsigned NUM_PINS   = 14;

  // Excitation sequence
  typedef enum logic [1:0] {
    SV_OFF     = 2'b00,
    SV_EXCITE  = 2'b01,
    SV_RELEASE = 2'b10,
    SV_READY   = 2'b11
  } servo_state_t;

endpackage : servo_io_pkg

/* verilog/servo_position_io_sequencer.sv */
// Servo drive I/O sequencer for pulse-train position mode: excitation, ready,
// motion, complete, near, brake timing, clear, preset, free and torque limit.
// Assumes pins arrive asynchronously and an AHB-Lite master reaches the settings.
`timescale 1ns/10ps
module servo_position_io_sequencer
  import servo_io_pkg::*;
#(
  parameter int unsigned EXCITE_CYC_P = EXCITE_CYC,  // Excitation settle, cycles
  parameter int unsigned BRAKE_CYC_P  = BRAKE_CYC,   // Brake release settle, cycles
  parameter int unsigned IDLE_CYC_P   = IDLE_CYC,    // Quiet time that ends motion, cycles
  parameter int unsigned CYC_MS_P     = CYC_PER_MS   // Cycles per millisecond tick
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Host control pins (asynchronous)
  input  wire logic        servo_on_in,
  input  wire logic        deviation_clear_in,
  input  wire logic        pos_request_in,
  input  wire logic        preset_in,
  input  wire logic        free_in,
  input  wire logic        torque_cap_in,
  input  wire logic        data_select_lo,
  input  wire logic        data_select_hi,
  // Pulse train and encoder feedback (asynchronous)
  input  wire logic        cmd_pulse_in,
  input  wire logic        cmd_dir_in,
  input  wire logic        fb_pulse_in,
  input  wire logic        fb_dir_in,
  // Power stage status (asynchronous)
  input  wire logic        main_power_ok_in,
  input  wire logic        fault_in,
  // Analog limit and torque feedback (same clock)
  input  wire logic [8:0]  analog_limit_in,
  input  wire logic [8:0]  motor_torque_in,
  // Host status pins
  output logic             ready_out,
  output logic             motion_out,
  output logic             complete_out,
  output logic             near_out,
  output logic             brake_timing_out,
  output logic             torque_capped_out,
  output logic             position_read_strobe,
  // Power stage and memory controls
  output logic             energize_out,
  output logic             brake_release_out,
  output logic      [8:0]  torque_ceiling_out,
  output logic      [7:0]  damping_freq_out,
  output logic             nvm_store_out,
  output logic      [31:0] nvm_data_out
);

  // Pin synchroniser: stage one feeds stage two only
  logic [NUM_PINS-1:0] pin_s1_ff;             // First stage
  logic [NUM_PINS-1:0] pin_ff;                // Second stage, safe to read
  logic [NUM_PINS-1:0] pin_prev_ff;           // Delayed copy for edge detection

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_ff   <= '0;
      pin_ff      <= '0;
      pin_prev_ff <= '0;
    end else begin
      pin_s1_ff   <= {fault_in, main_power_ok_in, fb_dir_in, fb_pulse_in, cmd_dir_in, cmd_pulse_in,
                      data_select_hi, data_select_lo, torque_cap_in, free_in, preset_in,
                      pos_request_in, deviation_clear_in, servo_on_in};
      pin_ff      <= pin_s1_ff;
      pin_prev_ff <= pin_ff;
    end
  end

  // Rising edges of the synchronised pins
  logic [NUM_PINS-1:0] pin_rise;
  assign pin_rise = pin_ff & ~pin_prev_ff;

  // Software settings
  logic [6:0]  ctrl_ff;                        // Control fields
  logic [31:0] complete_band_ff;               // Complete band, counts
  logic [31:0] near_band_ff;                   // Near band, counts
  logic [15:0] move_min_ff;                    // Motion minimum on-time, ms
  logic [31:0] preset_val_ff;                  // Value loaded by preset
  logic [8:0]  limit_ff [NUM_DSETS];           // Torque limit per set, percent
  logic [7:0]  damp_ff  [NUM_DSETS];           // Damping frequency per set, Hz

  // Internal state
  servo_state_t state_ff;                      // Excitation sequence
  servo_state_t nxt_state;
  logic [CNT_W-1:0]  seq_cnt_ff;               // Sequence settle counter
  logic signed [31:0] dev_ff;                  // Deviation counter
  logic [31:0] position_ff;                    // Current position
  logic        alarm_ff;                       // Alarm standing
  logic        warn_ff;                        // Main-supply warning
  logic [CNT_W-1:0]  idle_cnt_ff;              // Quiet cycles left before motion ends
  logic [CNT_W-1:0]  ms_cnt_ff;                // Millisecond prescaler
  logic [15:0] hold_ms_ff;                     // Remaining motion hold, ms

  // Decoded input functions
  logic servo_act;                             // Excitation requested
  logic clear_fn;                              // Clear acting as clear
  logic alarm_reset_in;                        // Clear acting as alarm reset
  logic dev_zero;                              // Any clearing condition
  logic accept_pulse;                          // Command pulse accepted
  logic moving;                                // Motor in motion
  logic [31:0] dev_abs;                        // Magnitude of deviation
  logic [1:0]  set_idx;                        // Active data set
  logic [8:0]  sel_limit;                      // Limit of the active set

  // Polarity setting: closed sense energizes with the pin off
  assign servo_act = ctrl_ff[CTRL_SON_NC] ? ~pin_ff[PIN_SON] : pin_ff[PIN_SON];
  // Position request turns clear into the read strobe
  assign clear_fn  = pin_ff[PIN_CLR] & ~pin_ff[PIN_PREQ];
  // Alarm reset on a clear edge, blocked by position request
  assign alarm_reset_in = alarm_ff & pin_rise[PIN_CLR] & ~pin_ff[PIN_PREQ];
  // Read strobe mirrors clear while position request is held
  assign position_read_strobe = pin_ff[PIN_CLR] & pin_ff[PIN_PREQ];

  // Deviation held at zero while disabled, cleared or free
  assign dev_zero = ~servo_act | clear_fn | pin_ff[PIN_FREE] | (state_ff == SV_OFF);
  // Pulses count only while ready; the host must wait for ready first
  assign accept_pulse = pin_rise[PIN_CMD] & ready_out;

  // Excitation sequence: energize, settle, release brake, settle, ready
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SV_OFF:     if (servo_act && pin_ff[PIN_MAINPW] && !alarm_ff && !pin_ff[PIN_FREE])
                    nxt_state = SV_EXCITE;
      SV_EXCITE:  if (seq_cnt_ff == CNT_W'(EXCITE_CYC_P - 1))
                    nxt_state = SV_RELEASE;
      SV_RELEASE: if (seq_cnt_ff == CNT_W'(BRAKE_CYC_P - 1))
                    nxt_state = SV_READY;
      SV_READY:   nxt_state = SV_READY;
    endcase
    // Any loss of conditions drops back to de-energized
    if (!servo_act || !pin_ff[PIN_MAINPW] || alarm_ff || pin_ff[PIN_FREE]) begin
      nxt_state = SV_OFF;
    end
  end

  // Sequence state and settle counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff   <= SV_OFF;
      seq_cnt_ff <= '0;
    end else begin
      state_ff   <= nxt_state;
      seq_cnt_ff <= (nxt_state != state_ff) ? '0 : seq_cnt_ff + CNT_W'(1);
    end
  end

  // Power stage: current only while sequenced and not freed
  assign energize_out      = (state_ff != SV_OFF);
  // Brake opens after excitation, or at once when freed
  assign brake_release_out = (state_ff == SV_RELEASE) | (state_ff == SV_READY) | pin_ff[PIN_FREE];

  // Ready needs every enabling condition
  assign ready_out = (state_ff == SV_READY) & pin_ff[PIN_MAINPW] & ~alarm_ff & servo_act
                   & ~pin_ff[PIN_FREE] & ~pin_ff[PIN_CLR] & ~ctrl_ff[CTRL_TEST];

  // Warning and alarm. Warning comes from enabling on auxiliary supply alone;
  // a pulse during the warning becomes an alarm. A new cause wins over a reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warn_ff  <= 1'b0;
      alarm_ff <= 1'b0;
    end else begin
      warn_ff  <= servo_act & ~pin_ff[PIN_MAINPW];
      if ((warn_ff && pin_rise[PIN_CMD]) || pin_ff[PIN_FAULT]) begin
        alarm_ff <= 1'b1;
      end else if (alarm_reset_in) begin
        alarm_ff <= 1'b0;
      end
    end
  end

  // Deviation counter: plus accepted commands, minus feedback
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dev_ff <= '0;
    end else if (dev_zero) begin
      dev_ff <= '0;
    end else begin
      dev_ff <= dev_ff
              + (accept_pulse ? (pin_ff[PIN_CDIR] ? -32'sd1 : 32'sd1) : 32'sd0)
              - (pin_rise[PIN_FB] ? (pin_ff[PIN_FDIR] ? -32'sd1 : 32'sd1) : 32'sd0);
    end
  end

  // Current position tracks feedback; preset overrides it. Only zero at power-up
  // is kept here; restoring a stored home belongs to the memory controller.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      position_ff   <= '0;
      nvm_store_out <= 1'b0;
      nvm_data_out  <= '0;
    end else begin
      nvm_store_out <= 1'b0;
      if (pin_rise[PIN_PRESET]) begin
        position_ff <= preset_val_ff;
        if (ctrl_ff[CTRL_ABS]) begin
          nvm_store_out <= 1'b1;
          nvm_data_out  <= preset_val_ff;
        end
      end else if (pin_rise[PIN_FB]) begin
        position_ff <= pin_ff[PIN_FDIR] ? position_ff - 32'd1 : position_ff + 32'd1;
      end
    end
  end

  // Motion detection: any accepted command or feedback pulse restarts the quiet timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt_ff <= '0;
    end else if (accept_pulse || pin_rise[PIN_FB]) begin
      idle_cnt_ff <= CNT_W'(IDLE_CYC_P);
    end else if (idle_cnt_ff != '0) begin
      idle_cnt_ff <= idle_cnt_ff - CNT_W'(1);
    end
  end
  assign moving = (idle_cnt_ff != '0);

  // Minimum on-time counted in millisecond ticks; a short motion still holds
  // the output for the full setting after it ends, the prescaler restarting with it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt_ff  <= '0;
      hold_ms_ff <= '0;
    end else if (moving) begin
      ms_cnt_ff  <= '0;
      hold_ms_ff <= move_min_ff;
    end else begin
      ms_cnt_ff  <= (ms_cnt_ff == CNT_W'(CYC_MS_P - 1)) ? '0 : ms_cnt_ff + CNT_W'(1);
      if (ms_cnt_ff == CNT_W'(CYC_MS_P - 1) && hold_ms_ff != '0) begin
        hold_ms_ff <= hold_ms_ff - 16'h0001;
      end
    end
  end

  // Band checks on the deviation magnitude
  assign dev_abs = dev_ff[31] ? 32'(-dev_ff) : 32'(dev_ff);

  // Status outputs, all registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      motion_out       <= 1'b0;
      complete_out     <= 1'b0;
      near_out         <= 1'b0;
      brake_timing_out <= 1'b0;
    end else begin
      motion_out       <= (ctrl_ff[CTRL_SEL1_LO +: 2] == SEL1_MOTION) & (moving | hold_ms_ff != '0);
      complete_out     <= ~moving & energize_out & (dev_abs <= complete_band_ff);
      // Near uses its own band but, like complete, waits for motion to end
      near_out         <= ctrl_ff[CTRL_SEL2] & ~moving & energize_out & (dev_abs <= near_band_ff);
      brake_timing_out <= (ctrl_ff[CTRL_SEL1_LO +: 2] == SEL1_BRAKE) & brake_release_out;
    end
  end

  // Torque limit set selection: upper select is the high bit
  assign set_idx   = {pin_ff[PIN_SEL_HI], pin_ff[PIN_SEL_LO]};
  // Set 0 follows the analog input when analog mode is on
  assign sel_limit = (ctrl_ff[CTRL_ANALOG] && set_idx == 2'd0) ? analog_limit_in : limit_ff[set_idx];

  // Torque ceiling and capped flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      torque_ceiling_out <= TORQUE_CEIL;
      torque_capped_out  <= 1'b0;
      damping_freq_out   <= DAMP_RST;
    end else begin
      torque_ceiling_out <= pin_ff[PIN_CAP] ? sel_limit : TORQUE_CEIL;
      torque_capped_out  <= pin_ff[PIN_CAP] & (motor_torque_in >= sel_limit);
      damping_freq_out   <= damp_ff[set_idx];
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  logic        acc_ff;                          // Data phase of a valid transfer
  logic        wr_ff;                           // That transfer is a write
  logic [7:0]  addr_ff;                         // Its byte offset
  logic        take;                            // Address phase accepted now
  logic [31:0] rd_mux;                          // Read data for the current address

  assign take      = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_mux = '0;
    unique case (haddr[7:0])
      OFS_CTRL:     rd_mux = {25'h0, ctrl_ff};
      OFS_COMPLETE: rd_mux = complete_band_ff;
      OFS_NEAR:     rd_mux = near_band_ff;
      OFS_MOVE_MIN: rd_mux = {16'h0, move_min_ff};
      OFS_PRESET:   rd_mux = preset_val_ff;
      OFS_STATUS:   rd_mux = {22'h0, state_ff, torque_capped_out, warn_ff, alarm_ff,
                              near_out, complete_out, motion_out, brake_release_out, ready_out};
      OFS_DEVIATE:  rd_mux = dev_ff;
      OFS_POSITION: rd_mux = position_ff;
      default: begin
        if (haddr[7:4] == OFS_DSET0[7:4] && haddr[1:0] == 2'h0) begin
          rd_mux = {8'h0, damp_ff[haddr[3:2]], 7'h0, limit_ff[haddr[3:2]]};
        end
      end
    endcase
  end

  // Address phase capture; read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ff  <= 1'b0;
      wr_ff   <= 1'b0;
      addr_ff <= '0;
      hrdata  <= '0;
    end else begin
      acc_ff  <= take;
      wr_ff   <= take & hwrite;
      if (take) begin
        addr_ff <= haddr[7:0];
      end
      if (take && !hwrite) begin
        hrdata <= (haddr[31:8] == 24'h0) ? rd_mux : 32'h0;
      end
    end
  end

  // Register writes in the data phase; read-only and unmapped offsets ignore them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff          <= CTRL_RST;
      complete_band_ff <= BAND_RST;
      near_band_ff     <= BAND_RST;
      move_min_ff      <= MOVE_MIN_RST;
      preset_val_ff    <= '0;
      for (int i = 0; i < NUM_DSETS; i++) begin
        limit_ff[i] <= LIMIT_RST;
        damp_ff[i]  <= DAMP_RST;
      end
    end else if (acc_ff && wr_ff) begin
      unique case (addr_ff)
        OFS_CTRL:     ctrl_ff          <= hwdata[6:0];
        OFS_COMPLETE: complete_band_ff <= hwdata;
        OFS_NEAR:     near_band_ff     <= hwdata;
        OFS_MOVE_MIN: move_min_ff      <= hwdata[15:0];
        OFS_PRESET:   preset_val_ff    <= hwdata;
        default: begin
          if (addr_ff[7:4] == OFS_DSET0[7:4] && addr_ff[1:0] == 2'h0) begin
            limit_ff[addr_ff[3:2]] <= hwdata[8:0];
            damp_ff[addr_ff[3:2]]  <= hwdata[DSET_DAMP_LO +: 8];
          end
        end
      endcase
    end
  end

endmodule : servo_position_io_sequencer

/* verification/host_pulse_model.sv */
// Host stand-in: sends command pulses and follows brake timing.
// Assumes the bench raises want; pulses leave only while ready is high.
`timescale 1ns/10ps
module host_pulse_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ready_out,
  input  wire logic       brake_timing_out,
  input  wire logic [7:0] want,
  output logic            cmd_pulse_in,
  output logic            brake_hold,
  output logic [7:0]      sent_ff
);
  logic [1:0] ph_ff;  // Two cycles high, two low, so the synchroniser sees each edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_ff <= 2'h0;
      cmd_pulse_in <= 1'b0;
      sent_ff <= 8'h00;
    end else begin
      ph_ff <= ph_ff + 2'h1;
      if (ph_ff == 2'h0 && sent_ff != want && ready_out) begin
        cmd_pulse_in <= 1'b1;
        sent_ff <= sent_ff + 8'h01;
      end else if (ph_ff == 2'h2) begin
        cmd_pulse_in <= 1'b0;
      end
    end
  end
  assign brake_hold = !brake_timing_out;
endmodule : host_pulse_model

/* verification/servo_seq_chk.sv */
// Checker: port relations of the servo I/O sequencer.
// Assumes pins stay put long enough to pass the synchroniser.
`timescale 1ns/10ps
module servo_seq_chk
  import servo_io_pkg::*;
(
  input wire logic       hclk, hresetn, main_power_ok_in, free_in, torque_cap_in,
  input wire logic       deviation_clear_in, pos_request_in, ready_out, energize_out,
  input wire logic       brake_release_out, position_read_strobe, torque_capped_out, nvm_store_out,
  input wire logic [8:0] motor_torque_in, torque_ceiling_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_cap_off; !torque_cap_in [*5]; endsequence
  sequence s_clr_held; (deviation_clear_in && !pos_request_in) [*5]; endsequence
  a_ready_released: assert property (ready_out |-> energize_out && brake_release_out) else $error("ready early");
  a_idle_no_ready: assert property (!energize_out |-> !ready_out) else $error("ready unpowered");
  a_power_gone: assert property (!main_power_ok_in [*5] |-> !ready_out) else $error("ready no power");
  a_free_cuts: assert property (free_in [*6] |-> !energize_out && brake_release_out) else $error("free");
  a_clear_blocks: assert property (s_clr_held |-> !ready_out) else $error("ready in clear");
  a_strobe_on: assert property ((deviation_clear_in && pos_request_in) [*4] |-> position_read_strobe) else $error("strobe");
  a_full_ceiling: assert property (s_cap_off |-> torque_ceiling_out == TORQUE_CEIL) else $error("ceiling");
  a_capped_limit: assert property (torque_capped_out |-> $past(motor_torque_in) >= torque_ceiling_out) else $error("cap");
  a_store_pulse: assert property (nvm_store_out |=> !nvm_store_out) else $error("store pulse");
endmodule : servo_seq_chk
bind servo_position_io_sequencer servo_seq_chk u_chk (.*);

/* verification/test_servo_position_io_sequencer.sv */
// Bench: drives pins and AHB-Lite, judges the sequencer's outputs.
// Assumes shortened settle counts and a host model making pulses.
`timescale 1ns/10ps
module test_servo_position_io_sequencer;
  import servo_io_pkg::*;
  logic hclk, hresetn, hsel, hwrite, servo_on_in, deviation_clear_in, pos_request_in, preset_in, free_in;
  logic torque_cap_in, data_select_lo, data_select_hi, main_power_ok_in, cmd_pulse_in, brake_hold;
  logic fault_in, cmd_dir_in, fb_pulse_in, fb_dir_in;
  logic hreadyout, hresp, ready_out, motion_out, complete_out, near_out, brake_timing_out;
  logic torque_capped_out, position_read_strobe, energize_out, brake_release_out, nvm_store_out;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, nvm_data_out, rd;
  logic [8:0] analog_limit_in, motor_torque_in, torque_ceiling_out;
  logic [7:0] damping_freq_out, want, sent;
  int error_cnt, compares, k;
  servo_position_io_sequencer #(.EXCITE_CYC_P(4), .BRAKE_CYC_P(4), .IDLE_CYC_P(8), .CYC_MS_P(4)) uut (.*,
    .hready(hreadyout), .hsize(3'h2));
  host_pulse_model host (.hclk, .hresetn, .ready_out, .brake_timing_out, .want, .cmd_pulse_in, .brake_hold,
    .sent_ff(sent));
  initial begin hclk = 1'b0; forever #2 hclk = ~hclk; end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin error_cnt++; $display("MISMATCH %s exp %h seen %h", n, e, s); end
  endtask : chk
  // One single word transfer; the answer is awaited, never assumed
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic t_regs;
    ahb(0, OFS_CTRL, 0); chk("ctrl", rd, 32'h52);
    for (int i = 0; i < 4; i++) begin ahb(0, OFS_DSET0 + 4*i, 0); chk("dset", rd, 32'h001e_0000); end
    ahb(0, 32'h40, 0); chk("unmapped", rd, 0);
    chk("resp", hresp, 0);
  endtask : t_regs
  task automatic t_ready;
    main_power_ok_in <= 1'b1; servo_on_in <= 1'b1;
    for (k = 0; k < 200 && ready_out !== 1'b1; k++) @(posedge hclk);
    chk("ready", ready_out, 1);
    chk("brake", brake_release_out, 1);
    ahb(1, OFS_CTRL, 32'h62); repeat (4) @(posedge hclk);
    chk("mbc", brake_timing_out, 1);
    chk("hold", brake_hold, 0);
    ahb(1, OFS_CTRL, 32'h52);
  endtask : t_ready
  task automatic t_pulse;
    want <= 8'h03;
    for (k = 0; k < 100 && motion_out !== 1'b1; k++) @(posedge hclk);
    chk("move", motion_out, 1);
    ahb(1, OFS_COMPLETE, 3);
    for (k = 0; k < 400 && complete_out !== 1'b1; k++) @(posedge hclk);
    chk("end", complete_out, 1);
    chk("near", near_out, 0);
    chk("movemin", motion_out, 1);
    ahb(0, OFS_DEVIATE, 0); chk("dev", rd, 3);
    deviation_clear_in <= 1'b1; repeat (6) @(posedge hclk);
    chk("clrready", ready_out, 0);
    ahb(0, OFS_DEVIATE, 0); chk("devclr", rd, 0);
    pos_request_in <= 1'b1; repeat (6) @(posedge hclk);
    chk("strobe", position_read_strobe, 1);
    deviation_clear_in <= 1'b0; pos_request_in <= 1'b0; repeat (6) @(posedge hclk);
  endtask : t_pulse
  task automatic t_preset;
    ahb(1, OFS_CTRL, 32'h56); ahb(1, OFS_PRESET, 32'h1234);
    preset_in <= 1'b1;
    for (k = 0; k < 20 && nvm_store_out !== 1'b1; k++) @(posedge hclk);
    chk("nvm", nvm_data_out, 32'h1234);
    ahb(0, OFS_POSITION, 0); chk("pos", rd, 32'h1234);
    preset_in <= 1'b0;
  endtask : t_preset
  task automatic t_torque;
    torque_cap_in <= 1'b1; repeat (6) @(posedge hclk);
    chk("analog", torque_ceiling_out, 9'h005);
    ahb(1, OFS_CTRL, 32'h50);
    for (int i = 0; i < 4; i++) ahb(1, OFS_DSET0 + 4*i, 32'h001e_0000 | (10*i + 10));
    for (int i = 0; i < 4; i++) begin
      {data_select_hi, data_select_lo} <= i[1:0]; repeat (6) @(posedge hclk);
      chk("limit", torque_ceiling_out, 10*i + 10);
      chk("capped", torque_capped_out, i < 2);
      chk("damp", damping_freq_out, 8'h1e);
    end
    torque_cap_in <= 1'b0; repeat (6) @(posedge hclk);
    chk("ceil", torque_ceiling_out, 9'h12c);
  endtask : t_torque
  // Alarm reset by clear is blocked while position request is held
  task automatic t_alarm;
    fault_in <= 1'b1; repeat (6) @(posedge hclk);
    chk("almready", ready_out, 0);
    fault_in <= 1'b0; deviation_clear_in <= 1'b1; pos_request_in <= 1'b1; repeat (6) @(posedge hclk);
    deviation_clear_in <= 1'b0; pos_request_in <= 1'b0; repeat (6) @(posedge hclk);
    ahb(0, OFS_STATUS, 0); chk("almkept", rd[5], 1);
    deviation_clear_in <= 1'b1; repeat (6) @(posedge hclk);
    deviation_clear_in <= 1'b0; repeat (20) @(posedge hclk);
    ahb(0, OFS_STATUS, 0); chk("almgone", rd[5], 0);
    chk("rearmed", ready_out, 1);
  endtask : t_alarm
  // Reverse commands and feedback move deviation and position; closed sense disables
  task automatic t_reverse;
    cmd_dir_in <= 1'b1; want <= 8'h05;
    for (k = 0; k < 100 && sent !== 8'h05; k++) @(posedge hclk);
    repeat (8) @(posedge hclk);
    fb_dir_in <= 1'b1; fb_pulse_in <= 1'b1; repeat (4) @(posedge hclk);
    fb_pulse_in <= 1'b0; repeat (4) @(posedge hclk);
    ahb(0, OFS_DEVIATE, 0); chk("devrev", rd, 32'hffff_ffff);
    ahb(0, OFS_POSITION, 0); chk("posfb", rd, 32'h1233);
    ahb(1, OFS_CTRL, 32'h51); repeat (6) @(posedge hclk);
    chk("ncready", ready_out, 0);
    ahb(0, OFS_DEVIATE, 0); chk("devoff", rd, 0);
    ahb(1, OFS_CTRL, 32'h50);
  endtask : t_reverse
  task automatic t_free;
    free_in <= 1'b1; repeat (8) @(posedge hclk);
    chk("energize", energize_out, 0);
    chk("brkfree", brake_release_out, 1);
    main_power_ok_in <= 1'b0; repeat (8) @(posedge hclk);
    chk("nopower", ready_out, 0);
  endtask : t_free
  task automatic report_and_stop;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  initial begin
    {hsel, hwrite, servo_on_in, deviation_clear_in, pos_request_in, preset_in, free_in, torque_cap_in} = '0;
    {data_select_lo, data_select_hi, main_power_ok_in, hresetn} = '0;
    {fault_in, cmd_dir_in, fb_pulse_in, fb_dir_in} = '0;
    htrans = 2'h0; haddr = 0; hwdata = 0; want = 8'h00; error_cnt = 0; compares = 0;
    analog_limit_in = 9'h005; motor_torque_in = 9'h014;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs; t_ready; t_pulse; t_preset; t_torque; t_alarm; t_reverse; t_free;
    report_and_stop;
  end
  // A hang counts as a mismatch
  initial begin #80000; error_cnt++; report_and_stop; end
endmodule : test_servo_position_io_sequencer
